// file: hdl/ldf_core.sv
// LED dimming, soft-start, switch timing and fault supervision core with an APB slave.
// Assumes analog front ends give synchronous rate and switch-level codes and async comparator levels.
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module ldf_core
	import ldf_pkg::*;
#(
	parameter int SS_STEP_CYCLES = SS_STEP_CYC,
	parameter int EN_OFF_CYCLES  = EN_OFF_CYC
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Asynchronous pin and comparator levels
	input  wire ldf_pins_t         pins_raw,
	// Synchronous analog codes
	input  wire logic [RES_W-1:0]  res_ohm,
	input  wire logic [7:0]        fsw_level,
	// Power stage and channel drive
	output logic [NUM_CH-1:0]      ch_on_q,
	output logic                   sw_gate_q,
	output logic                   sw_freq_1mhz_q,
	output logic                   pulse_skip_on_q,
	output logic [2:0]             ilim_code_q,
	output logic                   shutdown_q
);
	logic [PINS_W-1:0] pins_bits;
	ldf_pins_t         pins_s;
	logic              locked_q;
	logic              active;
	logic              qualify;
	logic [31:0]       ctrl_q;
	logic [31:0]       en_low_cnt_q;
	logic [LSB_W-1:0]  lsb_cycles_q;
	logic [LSB_W-1:0]  lsb_cnt_q;
	logic              lsb_tick;
	logic [DUTY_W-1:0] phase_q;
	logic              period_end;
	logic [DUTY_W:0]   hi_cnt_q;
	logic [DUTY_W:0]   duty_q;
	logic              pwm_prev_q;
	logic              mode_direct;
	logic              dim_event;
	logic [NUM_CH-1:0] base_on;
	ldf_band_t         band_q;
	logic [7:0]        sw_cnt_q;
	logic [7:0]        sw_period;
	logic [7:0]        sw_maxon;
	logic [31:0]       ss_cnt_q;
	logic [31:0]       ss_interval;
	logic [2:0]        ss_step_q;
	ldf_chstat_t       chs_q;
	logic [NUM_CH-1:0] on_dly1_q, on_dly2_q;
	logic [NUM_CH-1:0] expired;
	logic              apb_setup;
	logic              apb_write;
	logic [31:0]       rd_d;
	logic              err_d;

	ldf_sync #(
		.WIDTH (PINS_W)
	) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.din  (pins_raw),
		.dout (pins_bits)
	);
	assign pins_s = ldf_pins_t'(pins_bits);

	// Undervoltage latches until power-on reset only
	always_ff @(posedge clk) begin
		if (!rstn) begin
			locked_q <= 1'b0;
		end else if (pins_s.input_undervoltage_lockout) begin
			locked_q <= 1'b1;
		end
	end

	// Short enable dropouts are ridden through; only a long gap shuts down
	always_ff @(posedge clk) begin
		if (!rstn) begin
			en_low_cnt_q <= '0;
			shutdown_q   <= 1'b1;
		end else if (locked_q || pins_s.input_undervoltage_lockout) begin
			en_low_cnt_q <= '0;
			shutdown_q   <= 1'b1;
		end else if (pins_s.en) begin
			en_low_cnt_q <= '0;
			shutdown_q   <= 1'b0;
		end else if (en_low_cnt_q == 32'(EN_OFF_CYCLES - 1)) begin
			shutdown_q <= 1'b1;
		end else begin
			en_low_cnt_q <= en_low_cnt_q + 32'h0000_0001;
		end
	end

	assign active  = !shutdown_q && !locked_q && ctrl_q[0];
	assign qualify = active && pins_s.stable && !pins_s.otp;

	// Dimming period scales with the rate resistor
	always_ff @(posedge clk) begin
		if (!rstn) begin
			lsb_cycles_q <= 16'h0001;
		end else begin
			lsb_cycles_q <= LSB_W'((32'(res_ohm) * 32'(CLK_MHZ)) / 32'(DIM_DEN)) | 16'h0001;
		end
	end

	assign lsb_tick   = (lsb_cnt_q >= lsb_cycles_q - 16'h0001);
	assign period_end = lsb_tick && (phase_q == '1);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			lsb_cnt_q <= '0;
			phase_q   <= '0;
		end else if (lsb_tick) begin
			lsb_cnt_q <= '0;
			phase_q   <= phase_q + 8'h01;
		end else begin
			lsb_cnt_q <= lsb_cnt_q + 16'h0001;
		end
	end

	// Duty is sampled 256 times per period; a full-high period reads 256
	always_ff @(posedge clk) begin
		if (!rstn) begin
			hi_cnt_q <= '0;
			duty_q   <= '0;
		end else if (period_end) begin
			hi_cnt_q <= '0;
			duty_q   <= hi_cnt_q + 9'(pins_s.pwm);
		end else if (lsb_tick) begin
			hi_cnt_q <= hi_cnt_q + 9'(pins_s.pwm);
		end
	end

	assign mode_direct = pins_s.rate_float;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pwm_prev_q <= 1'b0;
		end else begin
			pwm_prev_q <= pins_s.pwm;
		end
	end

	// Time-out counts own periods, or host PWM edges when direct
	assign dim_event = mode_direct ? (pins_s.pwm && !pwm_prev_q) : period_end;

	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_phase
			logic [DUTY_W-1:0] rel;
			assign rel        = phase_q - DUTY_W'(c * PHASE_STEP);
			assign base_on[c] = mode_direct ? pins_s.pwm : ({1'b0, rel} < duty_q);
		end
	endgenerate

	// Zero duty and a low direct input both leave every source off
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ch_on_q <= '0;
		end else if (!active || pins_s.otp) begin
			ch_on_q <= '0;
		end else begin
			ch_on_q <= base_on & ~chs_q.disabled;
		end
	end

	// Current sense trails the drive by the synchroniser; an off channel is judged open only by overvoltage before it is good
	always_ff @(posedge clk) begin
		if (!rstn) begin
			on_dly1_q <= '0;
			on_dly2_q <= '0;
		end else begin
			on_dly1_q <= ch_on_q;
			on_dly2_q <= on_dly1_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			band_q <= BAND_600K_SKIP;
		end else if (fsw_level < BAND1_MIN) begin
			band_q <= BAND_600K_SKIP;
		end else if (fsw_level < BAND2_MIN) begin
			band_q <= BAND_600K_PWM;
		end else if (fsw_level < BAND3_MIN) begin
			band_q <= BAND_1M_PWM;
		end else begin
			band_q <= BAND_1M_SKIP;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sw_freq_1mhz_q  <= 1'b0;
			pulse_skip_on_q <= 1'b0;
		end else begin
			sw_freq_1mhz_q  <= (band_q == BAND_1M_PWM) || (band_q == BAND_1M_SKIP);
			pulse_skip_on_q <= ((band_q == BAND_600K_SKIP) || (band_q == BAND_1M_SKIP)) && pins_s.light_load;
		end
	end

	assign sw_period = sw_freq_1mhz_q ? SW_1M_CYC : SW_600K_CYC;
	assign sw_maxon  = 8'((32'(sw_period) * 32'(SW_MAXON_PCT)) / 32'd100);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sw_cnt_q <= '0;
		end else if (sw_cnt_q >= sw_period - 8'h01) begin
			sw_cnt_q <= '0;
		end else begin
			sw_cnt_q <= sw_cnt_q + 8'h01;
		end
	end

	// Current sense passes the synchroniser, so termination lags by two cycles
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sw_gate_q <= 1'b0;
		end else if (!active || pins_s.otp || pins_s.input_undervoltage_lockout) begin
			sw_gate_q <= 1'b0;
		end else if (pins_s.isw_over || sw_cnt_q >= sw_maxon) begin
			sw_gate_q <= 1'b0;
		end else if (sw_cnt_q == 8'h00 && !pulse_skip_on_q) begin
			sw_gate_q <= 1'b1;
		end
	end

	// Stretch stepping when slow dimming carries little charge per period
	assign ss_interval = (!mode_direct && lsb_cycles_q > SS_SLOW_LSB && duty_q < SS_LOW_DUTY) ?
		32'(2 * SS_STEP_CYCLES) : 32'(SS_STEP_CYCLES);

	always_ff @(posedge clk) begin
		if (!rstn || !active) begin
			ss_cnt_q  <= '0;
			ss_step_q <= '0;
		end else if (ss_step_q != 3'(SS_STEPS - 1)) begin
			if (ss_cnt_q >= ss_interval - 32'h0000_0001) begin
				ss_cnt_q  <= '0;
				ss_step_q <= ss_step_q + 3'h1;
			end else begin
				ss_cnt_q <= ss_cnt_q + 32'h0000_0001;
			end
		end
	end

	assign ilim_code_q = ss_step_q;

	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_fault
			always_ff @(posedge clk) begin
				if (!rstn || !active) begin
					chs_q.good[c]     <= 1'b0;
					chs_q.open_ch[c]  <= 1'b0;
					chs_q.shorted[c]  <= 1'b0;
					chs_q.disabled[c] <= 1'b0;
				end else begin
					if (qualify && pins_s.at_target[c]) begin
						chs_q.good[c] <= 1'b1;
					end
					if (qualify && ((chs_q.good[c] && ch_on_q[c] && on_dly2_q[c] && !pins_s.at_target[c])
						|| (pins_s.output_overvoltage_guard && !chs_q.good[c]))) begin
						chs_q.open_ch[c] <= 1'b1;
					end
					if (qualify && pins_s.short_hit[c]) begin
						chs_q.shorted[c] <= 1'b1;
					end
					if (expired[c]) begin
						chs_q.disabled[c] <= 1'b1;
					end
				end
			end

			ldf_fault_timer u_timer (
				.clk     (clk),
				.rstn    (rstn),
				.clr     (!active),
				.run     (chs_q.open_ch[c] || chs_q.shorted[c]),
				.event_p (dim_event),
				.limit   (mode_direct ? TO_DIRECT : TO_RSET),
				.expired (expired[c])
			);

			chk_overvolt_open: assert property (@(posedge clk) disable iff (!rstn)
				qualify && pins_s.output_overvoltage_guard && !chs_q.good[c] |=> chs_q.open_ch[c])
				else $error("overvoltage did not mark channel open");
			chk_disable_cause: assert property (@(posedge clk) disable iff (!rstn)
				$rose(chs_q.disabled[c]) |-> $past(chs_q.open_ch[c] || chs_q.shorted[c], 2))
				else $error("channel disabled without a fault");
		end
	endgenerate

	// APB: zero-wait slave, read data latched in the setup cycle
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pwrite;
	assign pready    = 1'b1;

	always_comb begin
		rd_d  = '0;
		err_d = 1'b0;
		unique case (paddr)
			ADDR_CTRL:   rd_d = ctrl_q;
			ADDR_STATUS: rd_d = {20'h00000, ss_step_q, locked_q, shutdown_q, pins_s.otp, mode_direct,
				pulse_skip_on_q, band_q, sw_gate_q, active};
			ADDR_CHSTAT: rd_d = {16'h0000, chs_q};
			ADDR_DUTY:   rd_d = {23'h000000, duty_q};
			default:     err_d = 1'b1;
		endcase
		if (pwrite && paddr != ADDR_CTRL) begin
			err_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (apb_setup) begin
			prdata  <= pwrite ? 32'h0000_0000 : rd_d;
			pslverr <= err_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl_q <= CTRL_RESET;
		end else if (apb_write && paddr == ADDR_CTRL) begin
			ctrl_q <= {31'h00000000, pwdata[0]};
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	chk_switch_limit: assert property (pins_s.isw_over && sw_gate_q |=> !sw_gate_q)
		else $error("switch stayed on after over-current");
	chk_otp_off: assert property (pins_s.otp |=> ch_on_q == '0 && !sw_gate_q)
		else $error("outputs not off under over-temperature");
	chk_direct_follow: assert property (active && mode_direct && !pins_s.otp
		|=> ch_on_q == ({NUM_CH{$past(pins_s.pwm)}} & ~$past(chs_q.disabled)))
		else $error("direct mode outputs do not follow input");
	chk_ss_restart: assert property (!active |=> ss_step_q == 3'h0 && ilim_code_q == 3'h0)
		else $error("soft-start not restarted at low limit");
	chk_ss_interval: assert property (active && ss_step_q != 3'(SS_STEPS - 1) && $past(active)
		##1 (ss_step_q != $past(ss_step_q)) |-> $past(ss_cnt_q) == $past(ss_interval) - 32'h0000_0001)
		else $error("soft-start stepped off its interval");
	chk_en_shutdown: assert property (!pins_s.en && !locked_q && !pins_s.input_undervoltage_lockout
		&& en_low_cnt_q == 32'(EN_OFF_CYCLES - 1) |=> shutdown_q)
		else $error("long enable gap did not shut down");
	sequence s_locked_idle;
		locked_q && !active ##1 !sw_gate_q;
	endsequence
	chk_lockout_hold: assert property (pins_s.input_undervoltage_lockout |=> s_locked_idle)
		else $error("undervoltage did not lock out");
	chk_band_low: assert property (fsw_level < BAND1_MIN |=> band_q == BAND_600K_SKIP)
		else $error("lowest switch band misdecoded");
	chk_zero_duty: assert property (!mode_direct && duty_q == '0 |=> ch_on_q == '0)
		else $error("channel on with zero duty");
endmodule

// file: hdl/ldf_pkg.sv
// Constants, packed carriers and register map of the LED dimming and fault control core.
// Assumes a 40 MHz core clock and comparator or ADC front ends that deliver digital levels.
// Operation
// - Dimming period grows with the rate resistor, so frequency is inverse to it.
// - Resistor mode digitizes input duty to 8 bits, up to 30kHz, 0.4% to 100%.
// - Floating rate pin selects direct mode; outputs follow input PWM, no phase shift.
// - Switch-rate level decodes to 600k pulse-skip, 600k PWM, 1M PWM, 1M pulse-skip.
// - Pulse-skip bands skip pulses only under light load, else fixed-frequency switching.
// - Soft-start limit begins at 225mA, seven more 225mA steps to 1.8A over 8ms.
// - Soft-start steps stretch at low dimming frequency with small duty.
// - Switch on-time ends at once when switch current exceeds present limit.
// - Channel above the 4.4V short threshold counts as shorted and gets disabled.
// - Channel reaching target current is good; later falling below makes it open.
// - Overvoltage at the output marks every channel not yet good as open.
// - An open channel is disabled only when its fault time-out expires.
// - Disabling one channel leaves the other channels running normally.
// - Fault qualification is held off while feedback reports an unstable boost.
// - Input undervoltage stops switching and resets; resume needs power-up and re-enable.
// - Over-temperature halts boost switching and turns off all current sources.
// - Fault time-out is 6 dimming cycles in resistor mode, 7 to 18 direct.
// - Resistor mode turns each channel on once per period, quarter period apart.
// - Enable inactive for longer than 28ms puts the device into shutdown.
// - PWM input held at zero disconnects all channel current sources.
package ldf_pkg;
	localparam int CLK_HZ       = 40_000_000;
	localparam int CLK_MHZ      = CLK_HZ / 1_000_000;
	localparam int NUM_CH       = 4;
	localparam int DUTY_W       = 8;
	localparam int RES_W        = 20;
	localparam int LSB_W        = 16;
	localparam int DIM_K_MHZ_OHM = 124;
	localparam int DIM_DEN      = DIM_K_MHZ_OHM * (1 << DUTY_W);
	localparam logic [DUTY_W-1:0] PHASE_STEP = 8'h40;
	localparam int SW_600K_HZ   = 600_000;
	localparam int SW_1M_HZ     = 1_000_000;
	localparam logic [7:0] SW_600K_CYC = 8'(CLK_HZ / SW_600K_HZ);
	localparam logic [7:0] SW_1M_CYC   = 8'(CLK_HZ / SW_1M_HZ);
	localparam int SW_MAXON_PCT = 90;
	localparam logic [7:0] BAND1_MIN = 8'h3A;
	localparam logic [7:0] BAND2_MIN = 8'h7C;
	localparam logic [7:0] BAND3_MIN = 8'hBE;
	localparam int ILIM_STEP_MA = 225;
	localparam int SS_STEPS     = 8;
	localparam int SS_TOTAL_MS  = 8;
	localparam int SS_STEP_CYC  = CLK_HZ / 1000 * SS_TOTAL_MS / SS_STEPS;
	localparam logic [LSB_W-1:0] SS_SLOW_LSB = 16'h009C;
	localparam logic [DUTY_W:0]  SS_LOW_DUTY = 9'h01A;
	localparam int EN_OFF_MS    = 28;
	localparam int EN_OFF_CYC   = CLK_HZ / 1000 * EN_OFF_MS;
	localparam logic [4:0] TO_RSET   = 5'h06;
	localparam logic [4:0] TO_DIRECT = 5'h0C;
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_CHSTAT = 12'h008;
	localparam logic [11:0] ADDR_DUTY   = 12'h00C;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;

	typedef enum logic [1:0] {BAND_600K_SKIP, BAND_600K_PWM, BAND_1M_PWM, BAND_1M_SKIP} ldf_band_t;

	typedef struct packed {
		logic              en;
		logic              pwm;
		logic              rate_float;
		logic              output_overvoltage_guard;
		logic              stable;
		logic              isw_over;
		logic              light_load;
		logic              otp;
		logic              input_undervoltage_lockout;
		logic [NUM_CH-1:0] short_hit;
		logic [NUM_CH-1:0] at_target;
	} ldf_pins_t;
	localparam int PINS_W = $bits(ldf_pins_t);

	typedef struct packed {
		logic [NUM_CH-1:0] shorted;
		logic [NUM_CH-1:0] disabled;
		logic [NUM_CH-1:0] open_ch;
		logic [NUM_CH-1:0] good;
	} ldf_chstat_t;
endpackage

// file: hdl/ldf_sync.sv
// Two-flop synchroniser bank for comparator and pin levels.
// Assumes each bit is a slow level; multi-bit words are not kept coherent.
`timescale 1ns/100ps
module ldf_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// Levels
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule

// file: hdl/ldf_fault_timer.sv
// Per-channel fault time-out counting dimming cycles.
// Assumes event is a one-cycle pulse on the core clock.
`timescale 1ns/100ps
module ldf_fault_timer (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Control
	input  wire logic       clr,
	input  wire logic       run,
	input  wire logic       event_p,
	input  wire logic [4:0] limit,
	// Result
	output logic            expired
);
	logic [4:0] cnt_q;

	always_ff @(posedge clk) begin
		if (!rstn || clr) begin
			cnt_q   <= '0;
			expired <= 1'b0;
		end else if (run && event_p && !expired) begin
			if (cnt_q == limit - 5'h01) begin
				expired <= 1'b1;
			end
			cnt_q <= cnt_q + 5'h01;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	chk_timer_expiry: assert property (run && event_p && !clr && !expired && cnt_q == limit - 5'h01 |=> expired)
		else $error("fault time-out did not expire at limit");
	chk_timer_early: assert property (!expired && !$past(clr) ##1 expired |-> $past(cnt_q) == $past(limit) - 5'h01)
		else $error("fault time-out expired early");
endmodule

// file: tb/ldf_led_model.sv
// LED strings, current sources and boost switch as seen from the core's pins.
// Assumes the bench commands the open, short and unstable conditions.
`timescale 1ns/100ps
module ldf_led_model
	import ldf_pkg::*;
(
	// Clock
	input  wire logic              clk,
	// Core drive
	input  wire logic [NUM_CH-1:0] ch_on,
	input  wire logic              gate,
	input  wire logic [2:0]        ilim,
	// Bench faults
	input  wire logic [NUM_CH-1:0] open_inj,
	input  wire logic [NUM_CH-1:0] short_inj,
	input  wire logic              hold_unstable,
	// Sensed levels
	output logic      [NUM_CH-1:0] at_target,
	output logic      [NUM_CH-1:0] short_hit,
	output logic                   stable,
	output logic                   isw_over
);
	int                on_cnt  = 0;
	int                settle  = 0;
	logic [NUM_CH-1:0] ch_prev = '0;
	always @(posedge clk) begin
		on_cnt <= gate ? on_cnt + 1 : 0;
		settle <= (ch_on != ch_prev) ? 8 : (settle > 0 ? settle - 1 : 0);
		ch_prev <= ch_on;
	end
	// Load steps upset the loop for a while
	assign stable    = !hold_unstable && settle == 0 && ch_on == ch_prev;
	// Inductor ramp crosses a low limit sooner
	assign isw_over  = gate && on_cnt >= 3 * (ilim + 1);
	assign at_target = ch_on & ~open_inj;
	assign short_hit = short_inj;
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the LED dimming and fault core.
// Assumes the LED model on the far side and shortened soft-start and enable counts.
`timescale 1ns/100ps
module tb_top
	import ldf_pkg::*;
;
	logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic        en = 1, pwm = 0, rate_float = 1, overvolt = 0, light_load = 0, otp = 0, undervolt = 0;
	logic        hold_unstable = 0, stable, isw_over, gate, gprev = 0, f1m, skip, shdn, pwm_run = 0, chk_on = 0;
	logic [3:0]  open_inj = '0, short_inj = '0, short_hit, at_target, ch_on, cprev = '0, exp_on = '0;
	logic [2:0]  ilim;
	logic [19:0] res_ohm = '0;
	logic [7:0]  fsw_level = 8'hD0;
	ldf_pins_t   pins;
	int          err_count = 0, cmp_count = 0, seed = 89, per = 1340, hi = 20, pc = 0, ncyc = 0, pmeas = 0;
	int          gcnt = 0, gper = 0, grise = 0, grun = 0, glast = 0;
	int          rise [4];

	assign pins = {en, pwm, rate_float, overvolt, stable, isw_over, light_load, otp, undervolt, short_hit, at_target};
	ldf_core #(.SS_STEP_CYCLES(20), .EN_OFF_CYCLES(50)) ldf_core_inst (.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins_raw(pins), .res_ohm(res_ohm), .fsw_level(fsw_level), .ch_on_q(ch_on),
		.sw_gate_q(gate), .sw_freq_1mhz_q(f1m), .pulse_skip_on_q(skip), .ilim_code_q(ilim), .shutdown_q(shdn));
	ldf_led_model ldf_led_model_inst (.clk(clk), .ch_on(ch_on), .gate(gate), .ilim(ilim), .open_inj(open_inj),
		.short_inj(short_inj), .hold_unstable(hold_unstable), .at_target(at_target), .short_hit(short_hit),
		.stable(stable), .isw_over(isw_over));

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Input PWM source, gate timing and channel edge capture
	always @(posedge clk) begin
		ncyc <= ncyc + 1;
		pc <= (pc + 1 >= per) ? 0 : pc + 1;
		pwm <= pwm_run && (pc < hi);
		if (chk_on && pc == 10)
			chk(32'(ch_on), 32'(exp_on));
		if (chk_on && pc == hi + 10)
			chk(32'(ch_on), 32'h0);
		cprev <= ch_on;
		for (int c = 0; c < 4; c++)
			if (ch_on[c] && !cprev[c])
				rise[c] <= ncyc;
		if (ch_on[0] && !cprev[0])
			pmeas <= ncyc - rise[0];
		gprev <= gate;
		grun <= gate ? grun + 1 : 0;
		if (gate && !gprev) begin
			gcnt <= gcnt + 1;
			gper <= ncyc - grise;
			grise <= ncyc;
		end
		if (!gate && gprev)
			glast <= grun;
	end

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp, input logic xerr);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r & m, exp);
		chk(32'(e), 32'(xerr));
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xerr);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		chk(32'(e), 32'(xerr));
	endtask

	// Reference: band decode and dimming step length
	function automatic int band_of(input int l);
		return (l >= BAND3_MIN) ? 3 : (l >= BAND2_MIN) ? 2 : (l >= BAND1_MIN) ? 1 : 0;
	endfunction
	function automatic int lsb_of(input int r);
		return ((r * CLK_MHZ) / DIM_DEN) | 1;
	endfunction

	// Each soft-start step after the first must take the given number of cycles, give or take one
	task automatic ss_check(input int step);
		int t;
		for (int k = 1; k < 8; k++) begin
			t = 0;
			while (ilim !== 3'(k) && t < 200) begin
				@(posedge clk);
				t++;
			end
			if (k > 1)
				chk(32'(t >= step - 1 && t <= step + 1), 32'h1);
		end
		cyc(3 * step);
		chk(32'(ilim), 32'h7);
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		cyc(95000);
		err_count++;
		$display("Error %0t: watchdog expired", $time);
		report_and_stop();
	end

	initial begin
		int          b, lvl, n, d, lsb, res;
		logic [31:0] r;
		logic        e;
		cyc(9);
		chk(32'({shdn, ch_on, ilim}), 32'h80);
		cyc(1);
		rstn <= 1'b1;
		cyc(2);
		chk(32'(ilim), 32'h0);
		ss_check(20);
		rd(ADDR_CTRL, 32'hFFFFFFFF, CTRL_RESET, 1'b0);
		rd(12'h010, 32'hFFFFFFFF, 32'h0, 1'b1);
		wr(ADDR_STATUS, 32'hFFFF, 1'b1);
		rd(ADDR_STATUS, 32'h20, 32'h20, 1'b0);
		for (int i = 0; i < 8; i++) begin
			lvl = (i % 4) * 64 + ($random(seed) & 'h1F);
			fsw_level <= 8'(lvl);
			light_load <= (i >= 4);
			cyc(200);
			n = gcnt;
			cyc(300);
			b = band_of(lvl);
			chk(32'(f1m), 32'(b >= 2));
			chk(32'(skip), 32'(i >= 4 && (b == 0 || b == 3)));
			rd(ADDR_STATUS, 32'hC, 32'(b) << 2, 1'b0);
			if (i >= 4 && (b == 0 || b == 3))
				chk(gcnt - n, 0);
			else
				chk(gper, b >= 2 ? 32'(SW_1M_CYC) : 32'(SW_600K_CYC));
		end
		chk(32'(glast <= 28 && glast > 0), 32'h1);
		light_load <= 1'b0;
		open_inj <= 4'h8;
		exp_on <= 4'hF;
		pwm_run <= 1'b1;
		cyc(per);
		chk_on <= 1'b1;
		cyc(2 * per);
		rd(ADDR_CHSTAT, 32'hFF, 32'h07, 1'b0);
		overvolt <= 1'b1;
		cyc(10);
		overvolt <= 1'b0;
		cyc(5);
		rd(ADDR_CHSTAT, 32'hFF, 32'h87, 1'b0);
		open_inj <= 4'hA;
		cyc(6 * per);
		chk_on <= 1'b0;
		cyc(13 * per);
		exp_on <= 4'h5;
		open_inj <= 4'h0;
		chk_on <= 1'b1;
		cyc(2 * per);
		rd(ADDR_CHSTAT, 32'hFF0, 32'hAA0, 1'b0);
		chk_on <= 1'b0;
		pwm_run <= 1'b0;
		wr(ADDR_CTRL, 32'h0, 1'b0);
		rd(ADDR_CHSTAT, 32'hFFFF, 32'h0, 1'b0);
		rate_float <= 1'b0;
		res_ohm <= 20'd160000;
		cyc(300);
		wr(ADDR_CTRL, 32'h1, 1'b0);
		ss_check(40);
		for (int j = 0; j < 2; j++) begin
			res = j ? 10320 : 5560;
			lsb = lsb_of(res);
			d = 8 + ($random(seed) & 'h7F);
			res_ohm <= 20'(res);
			per <= 256 * lsb;
			hi <= d * lsb;
			pwm_run <= 1'b1;
			cyc(3 * 256 * lsb);
			chk(pmeas, 256 * lsb);
			for (int c = 1; c < 4; c++)
				chk((rise[c] - rise[c - 1] + 256 * lsb) % (256 * lsb), 64 * lsb);
			apb(1'b0, ADDR_DUTY, 32'h0, r, e);
			chk(32'(r[8:0] + 1 - d <= 2), 32'h1);
		end
		res_ohm <= 20'd5560;
		per <= 1792;
		hi <= 100 * 7;
		hold_unstable <= 1'b1;
		short_inj <= 4'h4;
		cyc(6 * 1792);
		rd(ADDR_CHSTAT, 32'hF00, 32'h0, 1'b0);
		hold_unstable <= 1'b0;
		cyc(5 * 1792);
		rd(ADDR_CHSTAT, 32'hF00, 32'h0, 1'b0);
		cyc(3 * 1792);
		rd(ADDR_CHSTAT, 32'hFF00, 32'h4400, 1'b0);
		otp <= 1'b1;
		cyc(6);
		n = gcnt;
		cyc(200);
		chk(32'(ch_on), 32'h0);
		chk(gcnt - n, 0);
		otp <= 1'b0;
		en <= 1'b0;
		cyc(40);
		en <= 1'b1;
		cyc(5);
		chk(32'(shdn), 32'h0);
		en <= 1'b0;
		cyc(60);
		chk(32'(shdn), 32'h1);
		en <= 1'b1;
		cyc(10);
		undervolt <= 1'b1;
		cyc(6);
		undervolt <= 1'b0;
		cyc(20);
		chk(32'(shdn), 32'h1);
		rd(ADDR_STATUS, 32'h182, 32'h180, 1'b0);
		report_and_stop();
	end
endmodule
